// File: rtl/port_link_mgmt.sv
// Purpose: Link-down handling, slot power limit, link power states, upstream L1
//   entry and link-up / activity indicators for a four-port switch.
// Assumes: LTSSM, TLP and DLLP status come from core-clock logic; only the
//   fundamental reset pin is asynchronous.
// Notes: Indicators change only on the expander update tick.
// Contract
// - Link falling drops every queued TLP received on that port.
// - TLPs aimed at a link-down port are answered Unsupported Request.
// - Config accesses to a downstream bridge complete while its link is down.
// - Link coming up advertises flow control credits.
// - Received slot power message byte 0 stored as captured scale.
// - Received slot power message byte 1 bits 1:0 stored as captured value.
// - Slot capabilities write with link up sends a slot power message.
// - Downstream link becoming operational sends a slot power message.
// - L2/L3 Ready only after turn-off acknowledge; then link carries nothing.
// - L2 is left only by fundamental reset.
// - D3hot places the link in L1, besides automatic entry.
// - Link down reported for Detect, Polling, Config, Disabled, Loopback, Hot-Reset.
// - L1 needs rx lane in L0s, no DLLPs, no TLPs or no credits.
// - Conditions must hold for the programmed entry timer before requesting L1.
// - In L0/L0s request L1; ack enters L1, otherwise L0s.
// - Only the upstream port requests L1.
// - Upstream asks L1 only when active, linked downstream ports sit in L1.
// - Link-up indicator asserted in L0, L0s, L1, Recovery; else negated.
// - Activity indicator asserts on any non-vendor TLP sent or received.
// - Activity stays asserted at least 200 ms, restarted by each TLP.
// - Indicator outputs update no more often than every 40 ms.
`timescale 1ns/1ps
`default_nettype none

module port_link_mgmt
  import port_link_pkg::*;
#(
  parameter int unsigned P_ACT_HOLD = ACT_HOLD_CYCLES,
  parameter int unsigned P_TICK = EXP_UPDATE_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_fundamental_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire port_in_t [3:0] i_port,
  output port_out_t [3:0] o_port,
  input wire up_l1_in_t i_up,
  input wire spl_msg_t i_spl,
  output logic o_up_l1_req,
  output logic [3:0] o_port_link_up_ind_n,
  output logic [3:0] o_port_activity_ind_n
);

  if (P_ACT_HOLD < 1 || P_ACT_HOLD >= (1 << CNT_W))
  begin : g_bad_hold
    $error("P_ACT_HOLD out of counter range");
  end
  if (P_TICK < 1 || P_TICK > (1 << CNT_W))
  begin : g_bad_tick
    $error("P_TICK out of counter range");
  end

  state_t st;
  state_t next_st;
  logic [3:0] lu;
  logic [3:0] ld;
  logic [3:0] in_l1;
  logic [3:0] act_ev;
  logic [3:0] slot_wr;
  logic tick;
  logic ds_ok;
  logic l1_cond;
  logic [L1_CNT_W-1:0] l1_limit;

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    always_comb
    begin
      unique case (i_port[p].ltssm)
        LT_L0, LT_L0S, LT_L1, LT_RECOVERY:
        begin
          lu[p] = 1'b1;
          ld[p] = 1'b0;
        end
        LT_DETECT, LT_POLLING, LT_CONFIG, LT_DISABLED, LT_LOOPBACK, LT_HOT_RESET:
        begin
          lu[p] = 1'b0;
          ld[p] = 1'b1;
        end
        default:
        begin
          lu[p] = 1'b0;
          ld[p] = 1'b0;
        end
      endcase
    end
    assign in_l1[p] = (i_port[p].ltssm == LT_L1);
    // Vendor defined messages never light the activity indicator
    assign act_ev[p] = i_port[p].tlp_seen & ~i_port[p].tlp_vendor;
    assign o_port[p].flush = st.flush[p];
    assign o_port[p].fc_adv = st.fc_adv[p];
    assign o_port[p].slot_pwr_send = st.spl_send[p];
    // Config to the bridge itself is served locally, never rejected
    assign o_port[p].route_ur = i_port[p].route_req & ~i_port[p].route_is_cfg & ld[p];
    assign o_port[p].link_quiet = (st.pm[p] != PM_ACTIVE);
    assign o_port[p].l1_direct = st.d3hot[p] & lu[p] & ~in_l1[p]
      & (st.pm[p] == PM_ACTIVE);
  end

  assign slot_wr = {i_wr && (i_addr == ADDR_SLOTCAP3), i_wr && (i_addr == ADDR_SLOTCAP2),
                    i_wr && (i_addr == ADDR_SLOTCAP1), 1'b0};
  assign tick = (st.tick_cnt == '0);
  // Ports in D3 or link-down are not waited for
  assign ds_ok = &(st.d3hot[3:1] | ld[3:1] | in_l1[3:1]);
  assign l1_cond = i_up.rx_l0s & ~i_up.dllp_pend & (~i_up.tlp_pend | ~i_up.credit_ok)
    & ds_ok & (i_port[0].ltssm == LT_L0 || i_port[0].ltssm == LT_L0S)
    & (st.pm[0] == PM_ACTIVE);
  assign l1_limit = L1_CNT_W'(st.l1_timer) * L1_CNT_W'(L1_ENTRY_TIMER_UNIT_CYCLES);

  assign o_rdata = st.rdata;
  assign o_up_l1_req = (st.l1 == L1_REQ);
  assign o_port_link_up_ind_n = st.up_ind_n;
  assign o_port_activity_ind_n = st.act_ind_n;

  always_comb
  begin
    next_st = st;
    next_st.frst_meta = i_fundamental_reset_n;
    next_st.frst_sync = st.frst_meta;
    next_st.rdata = '0;

    if (i_wr && i_addr == ADDR_CTRL)
    begin
      next_st.l1_timer = i_wdata[CTRL_L1_ENTRY_TIMER_LSB +: 8];
      next_st.d3hot = i_wdata[CTRL_D3HOT_LSB +: 4];
    end
    for (int k = 0; k < 3; k++)
    begin
      if (slot_wr[k + 1])
      begin
        next_st.slotcap[k] = i_wdata;
      end
    end
    if (i_rd)
    begin
      unique case (i_addr)
        ADDR_CTRL:
        begin
          next_st.rdata[CTRL_L1_ENTRY_TIMER_LSB +: 8] = st.l1_timer;
          next_st.rdata[CTRL_D3HOT_LSB +: 4] = st.d3hot;
        end
        ADDR_DEVCAP:
        begin
          next_st.rdata[DEVCAP_SCALE_LSB +: 8] = st.cap_scale;
          next_st.rdata[DEVCAP_VALUE_LSB +: 2] = st.cap_value;
        end
        ADDR_SLOTCAP1: next_st.rdata = st.slotcap[0];
        ADDR_SLOTCAP2: next_st.rdata = st.slotcap[1];
        ADDR_SLOTCAP3: next_st.rdata = st.slotcap[2];
        ADDR_STATUS:
        begin
          next_st.rdata[STAT_UP_LSB +: 4] = lu;
          next_st.rdata[STAT_DOWN_LSB +: 4] = ld;
          next_st.rdata[STAT_L1_LSB +: 2] = st.l1;
          next_st.rdata[STAT_PM_LSB +: 8] = st.pm;
        end
        default: next_st.rdata = '0;
      endcase
    end

    if (i_spl.valid)
    begin
      next_st.cap_scale = i_spl.byte0;
      next_st.cap_value = i_spl.byte1[1:0];
    end

    for (int p = 0; p < NUM_PORTS; p++)
    begin
      next_st.prev_up[p] = lu[p];
      next_st.flush[p] = st.prev_up[p] & ~lu[p];
      // No credit update or message once turn-off has been acknowledged
      next_st.fc_adv[p] = ~st.prev_up[p] & lu[p] & (st.pm[p] == PM_ACTIVE);
      // Upstream port receives the message, never sends it
      next_st.spl_send[p] = (p != 0) && (st.pm[p] == PM_ACTIVE)
        && ((~st.prev_up[p] & lu[p])
        || (slot_wr[p] & lu[p]));

      if (act_ev[p])
      begin
        next_st.hold[p] = CNT_W'(P_ACT_HOLD);
      end
      else if (st.hold[p] != '0)
      begin
        next_st.hold[p] = st.hold[p] - 1'b1;
      end
      // Outputs may only move on the expander tick
      if (tick)
      begin
        next_st.up_ind_n[p] = ~lu[p];
        next_st.act_ind_n[p] = ~(act_ev[p] | (st.hold[p] != '0));
      end

      unique case (st.pm[p])
        PM_ACTIVE:
        begin
          if (i_port[p].turn_off_ack)
          begin
            next_st.pm[p] = PM_L23_READY;
          end
        end
        PM_L23_READY:
        begin
          if (i_port[p].main_pwr_off)
          begin
            next_st.pm[p] = PM_L2;
          end
        end
        PM_L2: next_st.pm[p] = PM_L2;
        default: next_st.pm[p] = PM_ACTIVE;
      endcase
      if (!st.frst_sync)
      begin
        next_st.pm[p] = PM_ACTIVE;
      end
    end

    next_st.tick_cnt = tick ? CNT_W'(P_TICK - 1) : st.tick_cnt - 1'b1;

    unique case (st.l1)
      L1_IDLE:
      begin
        if (!l1_cond)
        begin
          next_st.l1_cnt = '0;
        end
        else if (st.l1_cnt >= l1_limit)
        begin
          next_st.l1 = L1_REQ;
          next_st.l1_cnt = '0;
        end
        else
        begin
          next_st.l1_cnt = st.l1_cnt + 1'b1;
        end
      end
      L1_REQ:
      begin
        if (i_up.partner_ack)
        begin
          next_st.l1 = L1_IN;
        end
        else if (i_up.partner_nak)
        begin
          next_st.l1 = L1_L0S;
        end
      end
      L1_IN:
      begin
        if (i_port[0].ltssm == LT_RECOVERY || ld[0])
        begin
          next_st.l1 = L1_IDLE;
        end
      end
      L1_L0S: next_st.l1 = L1_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      st <= '0;
      st.frst_meta <= 1'b1;
      st.frst_sync <= 1'b1;
      st.l1_timer <= L1_ENTRY_TIMER_RST;
      st.d3hot <= D3HOT_RST;
      st.slotcap <= {3{SLOTCAP_RST}};
      st.act_ind_n <= 4'hF;
      st.up_ind_n <= 4'hF;
    end
    else
    begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence l1_asked;
    st.l1 == L1_REQ;
  endsequence

  // Refusal passes through L0s for one cycle before counting again
  sequence l1_fall_back;
    st.l1 == L1_L0S ##1 st.l1 == L1_IDLE;
  endsequence

  flush_on_down_a: assert property ($fell(lu[1]) |=> o_port[1].flush)
    else $error("no flush after link down");
  ur_when_down_a: assert property (i_port[2].route_req && !i_port[2].route_is_cfg
    && i_port[2].ltssm inside {LT_DETECT, LT_POLLING, LT_CONFIG, LT_DISABLED,
    LT_LOOPBACK, LT_HOT_RESET} |-> o_port[2].route_ur)
    else $error("request to down port not rejected");
  cfg_never_ur_a: assert property (i_port[3].route_is_cfg |-> !o_port[3].route_ur)
    else $error("config access rejected");
  fc_on_up_a: assert property ($rose(lu[0]) && st.pm[0] == PM_ACTIVE
    |=> o_port[0].fc_adv ##1 !o_port[0].fc_adv)
    else $error("credit advertise pulse wrong");
  spl_capture_a: assert property (i_spl.valid |=> st.cap_scale == $past(i_spl.byte0))
    else $error("slot power scale not captured");
  spl_value_a: assert property (i_spl.valid |=> st.cap_value == $past(i_spl.byte1[1:0]))
    else $error("slot power value not captured");
  spl_on_write_a: assert property (slot_wr[1] && lu[1] && st.pm[1] == PM_ACTIVE
    |=> o_port[1].slot_pwr_send)
    else $error("no slot power message after write");
  spl_on_up_a: assert property ($rose(lu[3]) && st.pm[3] == PM_ACTIVE
    |=> o_port[3].slot_pwr_send)
    else $error("no slot power message on link up");
  quiet_no_tx_a: assert property ($past(o_port[3].link_quiet)
    |-> !o_port[3].fc_adv && !o_port[3].slot_pwr_send)
    else $error("traffic after turn-off acknowledge");
  pm_entry_a: assert property (st.pm[1] == PM_ACTIVE && !i_port[1].turn_off_ack
    |=> st.pm[1] == PM_ACTIVE)
    else $error("left active without turn-off acknowledge");
  l2_stays_a: assert property (st.pm[0] == PM_L2 && st.frst_sync |=> st.pm[0] == PM_L2)
    else $error("left L2 without fundamental reset");
  l2_exit_a: assert property (!st.frst_sync |=> st.pm[0] == PM_ACTIVE)
    else $error("fundamental reset did not leave L2");
  d3_direct_a: assert property (st.d3hot[2] && i_port[2].ltssm == LT_L0
    && st.pm[2] == PM_ACTIVE |-> o_port[2].l1_direct)
    else $error("power state did not direct L1");
  down_report_a: assert property (i_port[1].ltssm inside {LT_DETECT, LT_POLLING,
    LT_CONFIG, LT_DISABLED, LT_LOOPBACK, LT_HOT_RESET} |-> ld[1] && !lu[1])
    else $error("link down not reported");
  l1_cond_need_a: assert property ($rose(o_up_l1_req) |-> $past(i_up.rx_l0s)
    && !$past(i_up.dllp_pend) && (!$past(i_up.tlp_pend) || !$past(i_up.credit_ok)))
    else $error("L1 requested without entry conditions");
  l1_gate_a: assert property ($rose(o_up_l1_req) |-> $past(l1_cond)
    && $past(st.l1_cnt) >= $past(l1_limit))
    else $error("L1 requested before timer expired");
  l1_restart_a: assert property (st.l1 == L1_IDLE && !l1_cond |=> st.l1_cnt == '0)
    else $error("entry timer not restarted");
  l1_from_l0_a: assert property ($rose(o_up_l1_req)
    |-> $past(i_port[0].ltssm) inside {LT_L0, LT_L0S})
    else $error("L1 requested outside L0 and L0s");
  l1_enter_a: assert property (l1_asked ##0 i_up.partner_ack |=> st.l1 == L1_IN)
    else $error("acknowledged L1 not entered");
  l1_answer_a: assert property (l1_asked ##0 i_up.partner_nak && !i_up.partner_ack
    |=> l1_fall_back)
    else $error("refused L1 did not fall back");
  ds_in_l1_a: assert property ($rose(o_up_l1_req) |-> $past(i_port[1].ltssm) == LT_L1
    || $past(st.d3hot[1]) || $past(ld[1]))
    else $error("L1 requested with downstream port awake");
  up_ind_a: assert property (tick && lu[1] |=> !o_port_link_up_ind_n[1])
    else $error("link-up indicator not asserted");
  ind_tick_a: assert property ($changed(o_port_link_up_ind_n) |-> $past(tick))
    else $error("indicator moved off tick");
  act_tick_a: assert property ($changed(o_port_activity_ind_n) |-> $past(tick))
    else $error("activity indicator moved off tick");
  tick_reload_a: assert property (tick |=> st.tick_cnt == CNT_W'(P_TICK - 1))
    else $error("expander period not reloaded");
  act_ind_a: assert property (tick && i_port[1].tlp_seen && !i_port[1].tlp_vendor
    |=> !o_port_activity_ind_n[1])
    else $error("activity indicator not asserted");
  vendor_skip_a: assert property (i_port[2].tlp_seen && i_port[2].tlp_vendor
    && st.hold[2] == '0 |=> st.hold[2] == '0)
    else $error("vendor message started activity hold");
  act_reload_a: assert property (act_ev[2] |=> st.hold[2] == CNT_W'(P_ACT_HOLD))
    else $error("activity hold not restarted");
  act_hold_a: assert property (tick && st.hold[1] != '0 |=> !o_port_activity_ind_n[1])
    else $error("activity released before hold ran out");

endmodule : port_link_mgmt

`default_nettype wire

// File: rtl/port_link_pkg.sv
// Purpose: Shared constants, types and register map for per-port link management.
// Assumes: 10 MHz core clock; port 0 is the upstream port, ports 1 to 3 downstream.
// Notes: Counts above 4096 cycles are overridable parameters of the top module.
package port_link_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Indicator timing
  localparam int unsigned ACT_HOLD_MS = 200;
  localparam int unsigned ACT_HOLD_CYCLES = ACT_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned EXP_UPDATE_MS = 40;
  localparam int unsigned EXP_UPDATE_CYCLES = EXP_UPDATE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 22;

  // L1 entry timer granularity: one field step is one microsecond
  localparam int unsigned L1_ENTRY_TIMER_UNIT_NS = 1000;
  localparam int unsigned L1_ENTRY_TIMER_UNIT_CYCLES = (L1_ENTRY_TIMER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned L1_CNT_W = 16;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEVCAP = 8'h04;
  localparam logic [7:0] ADDR_SLOTCAP1 = 8'h08;
  localparam logic [7:0] ADDR_SLOTCAP2 = 8'h0C;
  localparam logic [7:0] ADDR_SLOTCAP3 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Field positions
  localparam int unsigned CTRL_L1_ENTRY_TIMER_LSB = 0;
  localparam int unsigned CTRL_D3HOT_LSB = 8;
  localparam int unsigned DEVCAP_SCALE_LSB = 0;
  localparam int unsigned DEVCAP_VALUE_LSB = 8;
  localparam int unsigned STAT_UP_LSB = 0;
  localparam int unsigned STAT_DOWN_LSB = 4;
  localparam int unsigned STAT_L1_LSB = 8;
  localparam int unsigned STAT_PM_LSB = 12;

  // Values after reset
  localparam logic [7:0] L1_ENTRY_TIMER_RST = 8'h10;
  localparam logic [3:0] D3HOT_RST = 4'h0;
  localparam logic [31:0] SLOTCAP_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    LT_DETECT = 4'h0,
    LT_POLLING = 4'h1,
    LT_CONFIG = 4'h2,
    LT_L0 = 4'h3,
    LT_L0S = 4'h4,
    LT_L1 = 4'h5,
    LT_L2 = 4'h6,
    LT_RECOVERY = 4'h7,
    LT_DISABLED = 4'h8,
    LT_LOOPBACK = 4'h9,
    LT_HOT_RESET = 4'hA
  } ltssm_t;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_L23_READY = 2'b01,
    PM_L2 = 2'b11
  } pm_t;

  typedef enum logic [1:0] {
    L1_IDLE = 2'b00,
    L1_REQ = 2'b01,
    L1_IN = 2'b11,
    L1_L0S = 2'b10
  } l1_t;

  typedef struct packed {
    ltssm_t ltssm;
    logic tlp_seen;
    logic tlp_vendor;
    logic turn_off_ack;
    logic main_pwr_off;
    logic route_req;
    logic route_is_cfg;
  } port_in_t;

  typedef struct packed {
    logic flush;
    logic fc_adv;
    logic slot_pwr_send;
    logic route_ur;
    logic link_quiet;
    logic l1_direct;
  } port_out_t;

  typedef struct packed {
    logic rx_l0s;
    logic dllp_pend;
    logic tlp_pend;
    logic credit_ok;
    logic partner_ack;
    logic partner_nak;
  } up_l1_in_t;

  typedef struct packed {
    logic valid;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } spl_msg_t;

  typedef struct packed {
    logic frst_meta;
    logic frst_sync;
    logic [31:0] rdata;
    logic [7:0] l1_timer;
    logic [3:0] d3hot;
    logic [7:0] cap_scale;
    logic [1:0] cap_value;
    logic [2:0][31:0] slotcap;
    logic [3:0] prev_up;
    logic [3:0] flush;
    logic [3:0] fc_adv;
    logic [3:0] spl_send;
    logic [3:0] act_ind_n;
    logic [3:0] up_ind_n;
    logic [3:0][CNT_W-1:0] hold;
    logic [CNT_W-1:0] tick_cnt;
    pm_t [3:0] pm;
    l1_t l1;
    logic [L1_CNT_W-1:0] l1_cnt;
  } state_t;

endpackage : port_link_pkg

// File: tb/link_partner.sv
// Purpose: Far-end link partner answering the upstream L1 request.
// Assumes: The request is a level held until it has been answered.
// Notes: Answer delay and refusal are set by the bench.
`timescale 1ns/1ps
`default_nettype none

module link_partner
(
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_nak,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic o_nak
);
  logic [3:0] cnt = 4'h0;
  initial o_ack = 1'b0;
  initial o_nak = 1'b0;
  always @(posedge i_clk)
  begin
    o_ack <= 1'b0;
    o_nak <= 1'b0;
    cnt <= 4'h0;
    if (i_req && !o_ack && !o_nak)
    begin
      // A slow partner lets the request wait
      if (cnt == i_delay)
      begin
        o_ack <= !i_nak;
        o_nak <= i_nak;
      end
      else
      begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : link_partner
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for per-port link management.
// Assumes: Short hold and tick counts so indicator timing fits the run.
// Notes: Register reads are checked from a queue of expected words.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import port_link_pkg::*;
  localparam int HOLD = 20;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic frst_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata;
  port_in_t [3:0] pin = '0;
  port_out_t [3:0] pout;
  logic [3:0] up_lv = 4'h0;
  spl_msg_t spl = '0;
  logic l1_req;
  logic ack;
  logic nak;
  logic nak_sel = 1'b0;
  logic [3:0] up_n;
  logic [3:0] act_n;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h5;
  logic [31:0] r;
  int err_count = 0;
  int n_compared = 0;
  int k;

  always #50 i_clk = ~i_clk;

  port_link_mgmt #(.P_ACT_HOLD(HOLD), .P_TICK(4)) u_port_link_mgmt (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_fundamental_reset_n(frst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_port(pin), .o_port(pout),
    .i_up({up_lv, ack, nak}), .i_spl(spl), .o_up_l1_req(l1_req),
    .o_port_link_up_ind_n(up_n), .o_port_activity_ind_n(act_n));
  link_partner u_link_partner (.i_clk(i_clk), .i_req(l1_req), .i_nak(nak_sel),
    .i_delay(4'h2), .o_ack(ack), .o_nak(nak));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] stat(input logic [1:0] l1, input logic [7:0] pm);
    logic [31:0] s;
    s = '0;
    for (int p = 0; p < 4; p++)
    begin
      s[STAT_UP_LSB + p] = pin[p].ltssm inside {LT_L0, LT_L0S, LT_L1, LT_RECOVERY};
      s[STAT_DOWN_LSB + p] = pin[p].ltssm inside {LT_DETECT, LT_POLLING, LT_CONFIG,
        LT_DISABLED, LT_LOOPBACK, LT_HOT_RESET};
    end
    s[STAT_L1_LSB +: 2] = l1;
    s[STAT_PM_LSB +: 8] = pm;
    return s;
  endfunction : stat

  function automatic logic probe(input int w);
    case (w)
      0: return l1_req;
      1: return up_n[1];
      default: return act_n[1];
    endcase
  endfunction : probe

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  always @(posedge i_clk) rd_d <= rd;
  always @(negedge i_clk)
    if (rd_d)
      chk(rdata, exp_q.pop_front());

  task automatic at(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : at

  task automatic wait_sig(input int w, input logic v, input int lim);
    int i;
    i = 0;
    while (probe(w) !== v && i < lim)
    begin
      at(1);
      i++;
    end
    if (probe(w) !== v)
    begin
      err_count++;
      test_done();
    end
  endtask : wait_sig

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    rd <= 1'b0;
  endtask : rd_reg

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd_reg(ADDR_CTRL, {20'h0, D3HOT_RST, L1_ENTRY_TIMER_RST});
    rd_reg(ADDR_SLOTCAP1, SLOTCAP_RST);
    rd_reg(8'h40, 32'h0);
    for (k = 0; k < 11; k++)
    begin
      @(posedge i_clk);
      pin[3].ltssm <= ltssm_t'(k);
      @(posedge i_clk);
      rd_reg(ADDR_STATUS, stat(2'b00, 8'h00));
    end
    @(posedge i_clk);
    pin[1].ltssm <= LT_L0;
    at(1);
    chk(pout[1].fc_adv, 1'b1);
    chk(pout[1].slot_pwr_send, 1'b1);
    @(posedge i_clk);
    pin[1].ltssm <= LT_RECOVERY;
    at(1);
    chk(pout[1].flush, 1'b0);
    @(posedge i_clk);
    pin[1].ltssm <= LT_DETECT;
    at(1);
    chk(pout[1].flush, 1'b1);
    for (k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      pin[1].route_req <= 1'b1;
      pin[1].route_is_cfg <= k[0];
      at(0);
      chk(pout[1].route_ur, !k[0]);
    end
    pin[1].route_req <= 1'b0;
    wr_reg(ADDR_SLOTCAP1, rnd());
    at(0);
    chk(pout[1].slot_pwr_send, 1'b0);
    @(posedge i_clk);
    pin[1].ltssm <= LT_L0;
    at(3);
    r = rnd();
    wr_reg(ADDR_SLOTCAP1, r);
    at(0);
    chk(pout[1].slot_pwr_send, 1'b1);
    rd_reg(ADDR_SLOTCAP1, r);
    for (k = 0; k < 2; k++)
    begin
      r = rnd();
      @(posedge i_clk);
      spl <= {1'b1, r[7:0], r[15:8]};
      @(posedge i_clk);
      spl.valid <= 1'b0;
      rd_reg(ADDR_DEVCAP, {22'h0, r[9:8], r[7:0]});
    end
    at(0);
    chk(pout[3].link_quiet, 1'b0);
    @(posedge i_clk);
    pin[3].turn_off_ack <= 1'b1;
    @(posedge i_clk);
    pin[3].turn_off_ack <= 1'b0;
    pin[3].main_pwr_off <= 1'b1;
    at(2);
    chk(pout[3].link_quiet, 1'b1);
    rd_reg(ADDR_STATUS, stat(2'b00, 8'hC0));
    pin[3].main_pwr_off <= 1'b0;
    pin[3].turn_off_ack <= 1'b1;
    @(posedge i_clk);
    pin[3].turn_off_ack <= 1'b0;
    at(3);
    chk(pout[3].link_quiet, 1'b1);
    frst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    frst_n <= 1'b1;
    at(5);
    chk(pout[3].link_quiet, 1'b0);
    // Port 2 parked in D3hot, timer one step
    wr_reg(ADDR_CTRL, 32'h0000_0401);
    pin[0].ltssm <= LT_L0;
    pin[2].ltssm <= LT_L0;
    up_lv <= 4'b1010;
    at(30);
    chk(pout[2].l1_direct, 1'b1);
    chk(l1_req, 1'b0);
    pin[1].ltssm <= LT_L1;
    up_lv <= 4'b1011;
    at(30);
    chk(l1_req, 1'b0);
    up_lv <= 4'b1010;
    at(10);
    chk(l1_req, 1'b0);
    wait_sig(0, 1'b1, 5);
    wait_sig(0, 1'b0, 10);
    rd_reg(ADDR_STATUS, stat(2'b11, 8'h00));
    // Partner now refuses: retrain, then the next request must fall back
    nak_sel <= 1'b1;
    pin[0].ltssm <= LT_RECOVERY;
    at(2);
    pin[0].ltssm <= LT_L0;
    wait_sig(0, 1'b1, 20);
    wait_sig(0, 1'b0, 10);
    rd_reg(ADDR_STATUS, stat(2'b00, 8'h00));
    wait_sig(1, 1'b0, 10);
    chk(up_n, 4'b1000);
    chk(act_n, 4'hF);
    @(posedge i_clk);
    pin[2].tlp_seen <= 1'b1;
    pin[2].tlp_vendor <= 1'b1;
    @(posedge i_clk);
    pin[2].tlp_seen <= 1'b0;
    pin[1].tlp_seen <= 1'b1;
    @(posedge i_clk);
    pin[1].tlp_seen <= 1'b0;
    wait_sig(2, 1'b0, 10);
    chk(act_n[2], 1'b1);
    k = 0;
    while (act_n[1] === 1'b0 && k < 100)
    begin
      at(1);
      k++;
    end
    chk(k >= HOLD && k <= HOLD + 8, 1'b1);
    chk(k % 4, 0);
    test_done();
  end
endmodule : tb
`default_nettype wire
